// ==== rtl/modem_buffer_pkg.sv ====
// constants shared by the asynchronous modem buffer
package modem_buffer_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned BAUD_DEFAULT = 110;
  localparam int unsigned BAUD_MAX = 300;
  localparam int unsigned DIV_DEFAULT = CLK_HZ / BAUD_DEFAULT;
  localparam int unsigned DIV_MIN = CLK_HZ / BAUD_MAX;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned STOP_BITS = 2;
  localparam int unsigned FRAME_BITS = 1 + DATA_BITS + STOP_BITS;
  localparam logic [3:0] CMD_INHIBIT = 4'h4;
  localparam logic [3:0] CMD_ALLOW = 4'h8;
  localparam logic [7:0] STATION_DEFAULT = 8'h10;
  localparam logic MARK = 1'b1;
  localparam logic SPACE = 1'b0;
  localparam logic SREQ_EN_RESET = 1'b1;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01
  } tx_state_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_t;
endpackage

// ==== rtl/bit_timer_if.sv ====
// tick bundle from the local bit-rate generator
`timescale 1ns/1ps
interface bit_timer_if;
  logic restart;
  logic tick;
  logic half_tick;
  modport gen(input restart, output tick, output half_tick);
  modport use_side(output restart, input tick, input half_tick);
endinterface

// ==== rtl/bit_timer.sv ====
// local bit-rate generator with restart
`timescale 1ns/1ps
module bit_timer
  import modem_buffer_pkg::*;
#(
  parameter int unsigned DIV_W = 18
) (
  input wire logic clk_i,
  input wire logic rst_n,
  input wire logic [DIV_W-1:0] divisor_i,
  bit_timer_if.gen bt
);
  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;
  always_comb begin
    if (bt.restart || cnt_reg >= divisor_i - 1'b1) begin
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + 1'b1;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  assign bt.tick = !bt.restart && (cnt_reg >= divisor_i - 1'b1);
  assign bt.half_tick = !bt.restart && (cnt_reg == (divisor_i >> 1));
endmodule

// ==== rtl/async_modem_buffer.sv ====
// asynchronous start-stop modem buffer, transmitter and receiver
// Behaviour
// - each serial character is eleven units: start, eight data, two stop
// - start bit is space, stop bits are mark
// - receiver timing restarts at every incoming start bit
// - no modem clock; all bit timing from local clock
// - processor moves one whole 8-bit character per transfer
// - default line rate is 110 baud, ten characters per second
// - bit rate selectable above default up to 300 baud
// - transmit and receive run independently at the same time
// - idle transmitter holds line at mark
// - strap selects automatic or manual call answering and hang-up
// - receiver drops framing bits, keeps eight data bits for reading
// - service request per received or sent character, suppressible
// - command 4 inhibits, command 8 allows service requests
// - transmitter at even nonzero address, receiver at next odd
`timescale 1ns/1ps
module async_modem_buffer
  import modem_buffer_pkg::*;
#(
  parameter int unsigned DIV_W = 18,
  parameter logic [DIV_W-1:0] BIT_DIV = DIV_W'(DIV_DEFAULT),
  parameter logic [7:0] STATION = STATION_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [DIV_W-1:0] rate_div_i,
  input wire logic rate_sel_i,
  input wire logic [7:0] dev_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic cmd_i,
  input wire logic rd_i,
  output logic ack_o,
  output logic [7:0] rd_data_o,
  output logic tx_sreq_o,
  output logic rx_sreq_o,
  output logic txd_o,
  input wire logic rxd_i,
  input wire logic auto_answer_i,
  input wire logic ring_i,
  input wire logic carrier_i,
  output logic term_ready_o,
  output logic request_to_send_o
);
  logic rst_s1, rst_n;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  logic [DIV_W-1:0] divisor;
  logic tx_sel, rx_sel;
  always_comb begin
    divisor = BIT_DIV;
    if (rate_sel_i && rate_div_i >= DIV_W'(DIV_MIN)) begin
      divisor = rate_div_i;
    end
  end
  assign tx_sel = (STATION != 8'h00) && (dev_addr_i == {STATION[7:1], 1'b0});
  assign rx_sel = (STATION != 8'h00) && (dev_addr_i == {STATION[7:1], 1'b1});

  // transmitter
  bit_timer_if tx_bt();
  bit_timer #(.DIV_W(DIV_W)) u_tx_timer (
    .clk_i(clk_i), .rst_n(rst_n), .divisor_i(divisor), .bt(tx_bt)
  );
  tx_state_t tx_state_reg, tx_state_next;
  logic [10:0] tx_sh_reg, tx_sh_next;
  logic [3:0] tx_cnt_reg, tx_cnt_next;
  logic tx_pend_reg, tx_pend_next;
  logic tx_en_reg, tx_en_next;
  logic tx_load;
  assign tx_load = wr_i && tx_sel && tx_state_reg == TX_IDLE;
  assign tx_bt.restart = tx_load;
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_sh_next = tx_sh_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_pend_next = tx_pend_reg;
    tx_en_next = tx_en_reg;
    if (cmd_i && tx_sel && wr_data_i[3:0] == CMD_INHIBIT) tx_en_next = 1'b0;
    if (cmd_i && tx_sel && wr_data_i[3:0] == CMD_ALLOW) tx_en_next = 1'b1;
    if (wr_i && tx_sel) tx_pend_next = 1'b0;
    unique case (tx_state_reg)
      TX_IDLE: begin
        if (tx_load) begin
          tx_sh_next = {MARK, MARK, wr_data_i, SPACE};
          tx_cnt_next = 4'(FRAME_BITS - 1);
          tx_state_next = TX_SEND;
        end
      end
      TX_SEND: begin
        if (tx_bt.tick) begin
          tx_sh_next = {MARK, tx_sh_reg[10:1]};
          if (tx_cnt_reg == 4'h1) tx_pend_next = 1'b1;
          if (tx_cnt_reg == 4'h0) tx_state_next = TX_IDLE;
          else tx_cnt_next = tx_cnt_reg - 4'h1;
        end
      end
      default: tx_state_next = TX_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_reg <= TX_IDLE;
      tx_sh_reg <= 11'h7FF;
      tx_cnt_reg <= 4'h0;
      tx_pend_reg <= 1'b0;
      tx_en_reg <= SREQ_EN_RESET;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_sh_reg <= tx_sh_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_pend_reg <= tx_pend_next;
      tx_en_reg <= tx_en_next;
    end
  end
  assign txd_o = tx_sh_reg[0];
  assign tx_sreq_o = tx_pend_reg && tx_en_reg;

  // receiver, its own timer so both directions run at once
  bit_timer_if rx_bt();
  bit_timer #(.DIV_W(DIV_W)) u_rx_timer (
    .clk_i(clk_i), .rst_n(rst_n), .divisor_i(divisor), .bt(rx_bt)
  );
  rx_state_t rx_state_reg, rx_state_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic [7:0] rx_buf_reg, rx_buf_next;
  logic [3:0] rx_cnt_reg, rx_cnt_next;
  logic rx_pend_reg, rx_pend_next;
  logic rx_en_reg, rx_en_next;
  assign rx_bt.restart = rx_state_reg == RX_IDLE && rxd_i == SPACE;
  always_comb begin
    rx_state_next = rx_state_reg;
    rx_sh_next = rx_sh_reg;
    rx_buf_next = rx_buf_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_pend_next = rx_pend_reg;
    rx_en_next = rx_en_reg;
    if (cmd_i && rx_sel && wr_data_i[3:0] == CMD_INHIBIT) rx_en_next = 1'b0;
    if (cmd_i && rx_sel && wr_data_i[3:0] == CMD_ALLOW) rx_en_next = 1'b1;
    if (rd_i && rx_sel) rx_pend_next = 1'b0;
    unique case (rx_state_reg)
      RX_IDLE: begin
        if (rxd_i == SPACE) rx_state_next = RX_START;
      end
      RX_START: begin
        if (rx_bt.half_tick) begin
          if (rxd_i == SPACE) begin
            rx_state_next = RX_DATA;
            rx_cnt_next = 4'(DATA_BITS);
          end else begin
            rx_state_next = RX_IDLE;
          end
        end
      end
      RX_DATA: begin
        if (rx_bt.half_tick) begin
          rx_sh_next = {rxd_i, rx_sh_reg[7:1]};
          rx_cnt_next = rx_cnt_reg - 4'h1;
          if (rx_cnt_reg == 4'h1) begin
            rx_state_next = RX_STOP;
            rx_cnt_next = 4'(STOP_BITS);
          end
        end
      end
      RX_STOP: begin
        if (rx_bt.half_tick) begin
          rx_cnt_next = rx_cnt_reg - 4'h1;
          if (rx_cnt_reg == 4'h1) begin
            rx_buf_next = rx_sh_reg;
            rx_pend_next = 1'b1;
            rx_state_next = RX_IDLE;
          end
        end
      end
      default: rx_state_next = RX_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_reg <= RX_IDLE;
      rx_sh_reg <= 8'h00;
      rx_buf_reg <= 8'h00;
      rx_cnt_reg <= 4'h0;
      rx_pend_reg <= 1'b0;
      rx_en_reg <= SREQ_EN_RESET;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_sh_reg <= rx_sh_next;
      rx_buf_reg <= rx_buf_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_pend_reg <= rx_pend_next;
      rx_en_reg <= rx_en_next;
    end
  end
  assign rx_sreq_o = rx_pend_reg && rx_en_reg;

  // processor answer, data from a register
  logic ack_reg, ack_next;
  logic [7:0] rd_reg, rd_next;
  always_comb begin
    ack_next = (wr_i || cmd_i || rd_i) && (tx_sel || rx_sel);
    rd_next = rd_reg;
    if (rd_i && rx_sel) rd_next = rx_buf_reg;
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      rd_reg <= 8'h00;
    end else begin
      ack_reg <= ack_next;
      rd_reg <= rd_next;
    end
  end
  assign ack_o = ack_reg;
  assign rd_data_o = rd_reg;

  // call handling: automatic answers on ring, drops on lost carrier
  logic tr_reg, tr_next;
  always_comb begin
    tr_next = tr_reg;
    if (auto_answer_i) begin
      if (ring_i) tr_next = 1'b1;
      else if (tr_reg && !carrier_i && !ring_i) tr_next = 1'b0;
    end else begin
      tr_next = 1'b1;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tr_reg <= 1'b0;
    end else begin
      tr_reg <= tr_next;
    end
  end
  assign term_ready_o = tr_reg;
  assign request_to_send_o = tx_state_reg == TX_SEND;

  a_tx_idle_mark: assert property (@(posedge clk_i) disable iff (!rst_n)
    tx_state_reg == TX_IDLE |-> txd_o == MARK)
    else $error("idle line not mark");
  a_tx_start_space: assert property (@(posedge clk_i) disable iff (!rst_n)
    tx_load |=> txd_o == SPACE && tx_cnt_reg == 4'hA)
    else $error("start bit not space");
  a_rx_false_start: assert property (@(posedge clk_i) disable iff (!rst_n)
    rx_state_reg == RX_START && rx_bt.half_tick && rxd_i == MARK
    |=> rx_state_reg == RX_IDLE)
    else $error("false start accepted");
  a_rx_restart: assert property (@(posedge clk_i) disable iff (!rst_n)
    rx_state_reg == RX_IDLE && rxd_i == SPACE
    |=> u_rx_timer.cnt_reg == '0)
    else $error("timer not restarted");
  a_rx_done_req: assert property (@(posedge clk_i) disable iff (!rst_n)
    rx_state_reg == RX_STOP && rx_bt.half_tick && rx_cnt_reg == 4'h1
    |=> rx_pend_reg && rx_buf_reg == $past(rx_sh_reg))
    else $error("received byte lost");
  a_inhibit_cmd: assert property (@(posedge clk_i) disable iff (!rst_n)
    cmd_i && tx_sel && wr_data_i[3:0] == CMD_INHIBIT |=> !tx_sreq_o)
    else $error("inhibit ignored");
  a_allow_cmd: assert property (@(posedge clk_i) disable iff (!rst_n)
    cmd_i && rx_sel && wr_data_i[3:0] == CMD_ALLOW |=> rx_en_reg)
    else $error("allow ignored");
  a_addr_pair: assert property (@(posedge clk_i) disable iff (!rst_n)
    !(tx_sel && rx_sel))
    else $error("both sections selected");
  a_rate_floor: assert property (@(posedge clk_i) disable iff (!rst_n)
    rate_sel_i && rate_div_i < DIV_W'(DIV_MIN)
    |-> divisor == BIT_DIV)
    else $error("rate above maximum");
  a_lsb_first: assert property (@(posedge clk_i) disable iff (!rst_n)
    tx_load |=> tx_sh_reg[1] == $past(wr_data_i[0]))
    else $error("lsb not first");
  a_manual_ready: assert property (@(posedge clk_i) disable iff (!rst_n)
    !auto_answer_i |=> term_ready_o)
    else $error("manual mode not ready");
  a_auto_hangup: assert property (@(posedge clk_i) disable iff (!rst_n)
    auto_answer_i && term_ready_o && !carrier_i && !ring_i
    |=> !term_ready_o)
    else $error("no hang-up on lost carrier");
endmodule

// ==== tb/modem_model.sv ====
// behavioural modem: sends frames on rxd and decodes frames from txd
`timescale 1ns/1ps
module modem_model #(
  parameter int DIV = 16
) (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o
);
  logic [7:0] got_q[$];
  int bad = 0;
  initial rxd_o = 1'b1;
  task automatic send_char(input logic [7:0] b);
    logic [10:0] f;
    f = {2'b11, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd_o <= f[i];
      repeat (DIV) @(posedge clk_i);
    end
  endtask
  // short space pulse that must not be taken as a start bit
  task automatic glitch();
    rxd_o <= 1'b0;
    repeat (DIV / 4) @(posedge clk_i);
    rxd_o <= 1'b1;
  endtask
  always begin : decode
    logic [7:0] d;
    @(negedge txd_i);
    repeat (DIV / 2) @(posedge clk_i);
    if (txd_i !== 1'b0) bad++;
    for (int i = 0; i < 10; i++) begin
      repeat (DIV) @(posedge clk_i);
      if (i < 8) d[i] = txd_i;
      else if (txd_i !== 1'b1) bad++;
    end
    got_q.push_back(d);
  end
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the modem buffer
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  import modem_buffer_pkg::*;
  localparam int DIV = 16;
  localparam logic [7:0] TXA = 8'h10;
  localparam logic [7:0] RXA = 8'h11;
  typedef struct packed {logic [7:0] tx; logic [7:0] rx;} row_t;
  row_t rows[6] = '{16'h00FF, 16'hFF00, 16'hA55A, 16'h0180, 16'h8001,
    16'h3CC3};
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] dev_addr_i = 8'h00;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_i = 1'b0;
  logic cmd_i = 1'b0;
  logic rd_i = 1'b0;
  logic rate_sel_i = 1'b0;
  logic auto_answer_i = 1'b0;
  logic ring_i = 1'b0;
  logic carrier_i = 1'b0;
  logic [7:0] got_b;
  logic ack_o, tx_sreq_o, rx_sreq_o, txd_o, rxd, term_ready_o, rts;
  logic [7:0] rd_data_o;
  logic [7:0] rdat;
  logic got_ack;
  int n_mismatch = 0;
  int checked = 0;
  async_modem_buffer #(.BIT_DIV(18'(DIV))) u_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .rate_div_i(18'h00008),
    .rate_sel_i(rate_sel_i), .dev_addr_i(dev_addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .cmd_i(cmd_i), .rd_i(rd_i), .ack_o(ack_o),
    .rd_data_o(rd_data_o), .tx_sreq_o(tx_sreq_o), .rx_sreq_o(rx_sreq_o),
    .txd_o(txd_o), .rxd_i(rxd), .auto_answer_i(auto_answer_i),
    .ring_i(ring_i), .carrier_i(carrier_i), .term_ready_o(term_ready_o),
    .request_to_send_o(rts));
  modem_model #(.DIV(DIV)) u_modem (
    .clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd));
  // k: 0 write, 1 command, 2 read
  task automatic op(input logic [7:0] a, d, input int k);
    @(posedge clk_i);
    dev_addr_i <= a;
    wr_data_i <= d;
    wr_i <= (k == 0);
    cmd_i <= (k == 1);
    rd_i <= (k == 2);
    @(posedge clk_i);
    {wr_i, cmd_i, rd_i} <= 3'b000;
    got_ack = 1'b0;
    for (int i = 0; i < 3; i++) begin
      #1;
      if (ack_o === 1'b1) begin
        got_ack = 1'b1;
        rdat = rd_data_o;
      end
      @(posedge clk_i);
    end
    #1;
  endtask
  task automatic stop_test();
    $display("mismatches=%0d checks=%0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // s: 0 transmit request, 1 receive request
  task automatic wait_hi(input int s);
    int i;
    for (i = 0; i < 20 * DIV; i++) begin
      @(posedge clk_i);
      #1;
      if ((s ? rx_sreq_o : tx_sreq_o) === 1'b1) break;
    end
    if (i == 20 * DIV) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  initial forever #25 clk_i = ~clk_i;
  initial begin
    repeat (100000) @(posedge clk_i);
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    #1;
    `CHK(txd_o, MARK)
    `CHK({ack_o, tx_sreq_o, rx_sreq_o}, 3'b000)
    @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    #1;
    `CHK(term_ready_o, 1'b1)
    foreach (rows[i]) begin
      fork
        begin
          op(TXA, rows[i].tx, 0);
          #1;
          `CHK(rts, 1'b1)
        end
        u_modem.send_char(rows[i].rx);
      join
      `CHK(got_ack, 1'b1)
      wait_hi(0);
      wait_hi(1);
      repeat (2 * DIV) @(posedge clk_i);
      `CHK(u_modem.got_q.size(), 1)
      got_b = u_modem.got_q.pop_front();
      `CHK(got_b, rows[i].tx)
      op(RXA, 8'h00, 2);
      `CHK(rdat, rows[i].rx)
      #1;
      `CHK({tx_sreq_o, rx_sreq_o}, 2'b10)
    end
    op(TXA, {4'h0, CMD_INHIBIT}, 1);
    `CHK(got_ack, 1'b1)
    op(TXA, 8'h66, 0);
    repeat (13 * DIV) @(posedge clk_i);
    #1;
    `CHK(tx_sreq_o, 1'b0)
    got_b = u_modem.got_q.pop_front();
    `CHK(got_b, 8'h66)
    op(TXA, {4'h0, CMD_ALLOW}, 1);
    `CHK(tx_sreq_o, 1'b1)
    op(RXA, {4'h0, CMD_INHIBIT}, 1);
    u_modem.send_char(8'h99);
    repeat (2 * DIV) @(posedge clk_i);
    #1;
    `CHK(rx_sreq_o, 1'b0)
    op(RXA, {4'h0, CMD_ALLOW}, 1);
    `CHK(rx_sreq_o, 1'b1)
    op(RXA, 8'h00, 2);
    `CHK(rdat, 8'h99)
    // a divisor below the floor must be ignored, so frames keep the default rate
    @(posedge clk_i);
    rate_sel_i <= 1'b1;
    op(TXA, 8'h11, 0);
    op(TXA, 8'h22, 0);
    `CHK(got_ack, 1'b1)
    repeat (26 * DIV) @(posedge clk_i);
    `CHK(u_modem.got_q.size(), 1)
    got_b = u_modem.got_q.pop_front();
    `CHK(got_b, 8'h11)
    op(8'h12, 8'h55, 0);
    `CHK(got_ack, 1'b0)
    repeat (DIV) @(posedge clk_i);
    #1;
    `CHK({txd_o, rts}, 2'b10)
    op(8'h13, 8'h00, 2);
    `CHK(got_ack, 1'b0)
    u_modem.glitch();
    repeat (12 * DIV) @(posedge clk_i);
    #1;
    `CHK(rx_sreq_o, 1'b0)
    u_modem.send_char(8'h5B);
    wait_hi(1);
    op(RXA, 8'h00, 2);
    `CHK(rdat, 8'h5B)
    // automatic mode: answer on ring, hold while carrier, drop without it
    @(posedge clk_i);
    auto_answer_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(term_ready_o, 1'b0)
    @(posedge clk_i);
    ring_i <= 1'b1;
    carrier_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    ring_i <= 1'b0;
    #1;
    `CHK(term_ready_o, 1'b1)
    repeat (2) @(posedge clk_i);
    carrier_i <= 1'b0;
    #1;
    `CHK(term_ready_o, 1'b1)
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(term_ready_o, 1'b0)
    @(posedge clk_i);
    auto_answer_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(term_ready_o, 1'b1)
    `CHK(u_modem.bad, 0)
    stop_test();
  end
endmodule
